// ==== amd_core.sv ====
// instruction fetch and effective address sequencer
//
// What this block does
// - inherent instructions are one byte, two with a prefix; no operand bytes fetched
// - inherent group: control, return, flag, stack and register-form ops
// - immediate is opcode then literal byte, for load/compare/logic/add
// - load, compare, logic, arithmetic take short and long memory forms
// - short direct: one address byte, page zero
// - long direct: two-byte address, full 64 Kbyte space
// - indexed: unsigned sum of x or y with the instruction offset
// - indexed no offset: no byte follows, index alone is the address
// - short indexed: one offset byte, sum reaches 1fe
// - long indexed: word offset plus index, full space
// - indirect: byte after opcode addresses a pointer read from memory
// - short indirect: byte pointer address, byte pointer
// - long indirect: byte pointer address, word pointer
// - indirect indexed: index plus pointer read from memory
// - short indirect indexed: byte pointer, sum reaches 1fe
// - long indirect indexed: word pointer plus index, full space
// - memory-to-memory ops take only short forms
// - relative: pc plus sign-extended 8-bit offset
// - only conditional jumps and relative call use relative mode
// - relative base pc already points at the next instruction
// - relative direct: offset follows; indirect: offset byte in memory
// - prefixes 90, 92, 91 switch to y, indirect, y indirect
`timescale 1ns/10ps
module amd_core (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   // datapath control
   input wire logic go_i,
   input wire logic pc_load_i,
   input wire logic [amd_pkg::ADDR_W-1:0] pc_value_i,
   input wire logic [amd_pkg::DATA_W-1:0] x_i,
   input wire logic [amd_pkg::DATA_W-1:0] y_i,
   // memory read bus
   output logic mem_rd_o,
   output logic [amd_pkg::ADDR_W-1:0] mem_addr_o,
   input wire logic [amd_pkg::DATA_W-1:0] mem_rdata_i,
   input wire logic mem_ack_i,
   // decode result
   output logic busy_o,
   output logic done_o,
   output logic [amd_pkg::DATA_W-1:0] opcode_o,
   output amd_pkg::amd_mode_t mode_o,
   output logic use_y_o,
   output logic illegal_o,
   output logic [amd_pkg::DATA_W-1:0] operand_o,
   output logic [amd_pkg::ADDR_W-1:0] ea_o,
   output logic [2:0] instr_len_o,
   output logic [amd_pkg::ADDR_W-1:0] pc_o
);
   import amd_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_OPC = 6'h02,
      ST_DEC = 6'h04,
      ST_OPD = 6'h08,
      ST_PTR = 6'h10,
      ST_DONE = 6'h20
   } amd_state_t;

   amd_state_t state_q;
   logic rd_q;
   logic [15:0] addr_q;
   logic cnt_q;
   logic [15:0] pc_q;
   logic [7:0] opc_q;
   logic pfx_y_q;
   logic pfx_iy_q;
   logic pfx_ind_q;
   logic [15:0] opd_q;
   logic [15:0] ptr_q;
   logic busy_q;
   logic done_q;
   logic [7:0] opcode_q;
   amd_mode_t mode_q;
   logic use_y_q;
   logic ill_q;
   logic [7:0] operand_q;
   logic [15:0] ea_q;
   logic [2:0] len_q;
   logic [15:0] pc_out_q;

   logic take;
   logic is_pfx;
   logic pfx_any;
   amd_mode_t dec_mode;
   logic dec_use_y;
   logic dec_ill;
   logic [1:0] opd_n;
   logic [1:0] ptr_n;
   logic [15:0] ea;

   // a byte is accepted when a request is open and acknowledged
   assign take = rd_q & mem_ack_i;
   assign is_pfx = (mem_rdata_i == PFX_Y) | (mem_rdata_i == PFX_IY)
                   | (mem_rdata_i == PFX_IND);
   assign pfx_any = pfx_y_q | pfx_iy_q | pfx_ind_q;

   // opcode table
   amd_opcode_dec u_dec (
      .opcode_i (opc_q),
      .pfx_y_i (pfx_y_q),
      .pfx_iy_i (pfx_iy_q),
      .pfx_ind_i (pfx_ind_q),
      .mode_o (dec_mode),
      .use_y_o (dec_use_y),
      .illegal_o (dec_ill),
      .opd_n_o (opd_n),
      .ptr_n_o (ptr_n)
   );

   // address arithmetic; pc_q already points past the instruction
   amd_ea_calc u_ea (
      .mode_i (dec_mode),
      .opd_i (opd_q),
      .ptr_i (ptr_q),
      .idx_i (dec_use_y ? y_i : x_i),
      .pc_i (pc_q),
      .ea_o (ea)
   );

   // sequencer and memory request
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ST_IDLE;
         rd_q <= 1'b0;
         addr_q <= PC_RESET_VAL;
         cnt_q <= 1'b0;
      end
      else if (en_i)
      begin
         case (state_q)
            ST_IDLE:
               if (go_i && !pc_load_i)
               begin
                  state_q <= ST_OPC;
                  rd_q <= 1'b1;
                  addr_q <= pc_q;
               end
            ST_OPC:
               if (take)
               begin
                  addr_q <= pc_q + 16'h0001;
                  if (!(is_pfx && !pfx_any))
                  begin
                     state_q <= ST_DEC; // prefix keeps the request open
                     rd_q <= 1'b0;
                  end
               end
            ST_DEC:
               if (opd_n != 2'd0)
               begin
                  state_q <= ST_OPD;
                  rd_q <= 1'b1;
                  cnt_q <= (opd_n == 2'd2);
               end
               else
                  state_q <= ST_DONE;
            ST_OPD:
               if (take)
               begin
                  if (cnt_q)
                  begin
                     cnt_q <= 1'b0;
                     addr_q <= pc_q + 16'h0001;
                  end
                  else if (ptr_n != 2'd0)
                  begin
                     state_q <= ST_PTR;
                     addr_q <= {8'h00, mem_rdata_i};
                     cnt_q <= (ptr_n == 2'd2);
                  end
                  else
                  begin
                     state_q <= ST_DONE;
                     rd_q <= 1'b0;
                  end
               end
            ST_PTR:
               if (take)
               begin
                  if (cnt_q)
                  begin
                     cnt_q <= 1'b0;
                     addr_q <= addr_q + 16'h0001;
                  end
                  else
                  begin
                     state_q <= ST_DONE;
                     rd_q <= 1'b0;
                  end
               end
            ST_DONE:
               state_q <= ST_IDLE;
            default:
            begin
               state_q <= ST_IDLE;
               rd_q <= 1'b0;
            end
         endcase
      end
   end

   // program counter, advanced by each instruction byte only
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pc_q <= PC_RESET_VAL;
      else if (en_i)
      begin
         if (state_q == ST_IDLE && pc_load_i)
            pc_q <= pc_value_i;
         else if (take && (state_q == ST_OPC || state_q == ST_OPD))
            pc_q <= pc_q + 16'h0001;
      end
   end

   // opcode, prefix and operand capture
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         opc_q <= 8'h00;
         pfx_y_q <= 1'b0;
         pfx_iy_q <= 1'b0;
         pfx_ind_q <= 1'b0;
         opd_q <= 16'h0000;
         ptr_q <= 16'h0000;
      end
      else if (en_i)
      begin
         if (state_q == ST_IDLE && go_i && !pc_load_i)
         begin
            pfx_y_q <= 1'b0;
            pfx_iy_q <= 1'b0;
            pfx_ind_q <= 1'b0;
            opd_q <= 16'h0000;
            ptr_q <= 16'h0000;
         end
         else if (take && state_q == ST_OPC)
         begin
            if (is_pfx && !pfx_any)
            begin
               pfx_y_q <= (mem_rdata_i == PFX_Y);
               pfx_iy_q <= (mem_rdata_i == PFX_IY);
               pfx_ind_q <= (mem_rdata_i == PFX_IND);
            end
            else
               opc_q <= mem_rdata_i;
         end
         else if (take && state_q == ST_OPD)
            opd_q <= {opd_q[7:0], mem_rdata_i};
         else if (take && state_q == ST_PTR)
            ptr_q <= {ptr_q[7:0], mem_rdata_i};
      end
   end

   // busy flag and result registers
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         opcode_q <= 8'h00;
         mode_q <= M_INH;
         use_y_q <= 1'b0;
         ill_q <= 1'b0;
         operand_q <= 8'h00;
         ea_q <= 16'h0000;
         len_q <= 3'd0;
         pc_out_q <= PC_RESET_VAL;
      end
      else if (en_i)
      begin
         done_q <= (state_q == ST_DONE);
         if (state_q == ST_IDLE && go_i && !pc_load_i)
            busy_q <= 1'b1;
         else if (state_q == ST_DONE)
            busy_q <= 1'b0;
         if (state_q == ST_DONE)
         begin
            opcode_q <= opc_q;
            mode_q <= dec_mode;
            use_y_q <= dec_use_y;
            ill_q <= dec_ill;
            operand_q <= opd_q[7:0];
            ea_q <= (dec_mode == M_IMM || dec_mode == M_INH) ? 16'h0000 : ea;
            len_q <= {2'b00, pfx_any} + 3'd1 + {1'b0, opd_n};
            pc_out_q <= pc_q;
         end
      end
   end

   // outputs straight from flip-flops
   assign mem_rd_o = rd_q;
   assign mem_addr_o = addr_q;
   assign busy_o = busy_q;
   assign done_o = done_q;
   assign opcode_o = opcode_q;
   assign mode_o = mode_q;
   assign use_y_o = use_y_q;
   assign illegal_o = ill_q;
   assign operand_o = operand_q;
   assign ea_o = ea_q;
   assign instr_len_o = len_q;
   assign pc_o = pc_out_q;
endmodule

// ==== amd_pkg.sv ====
// shared constants and types of the addressing mode decoder
package amd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // reset value of the fetch program counter
   localparam logic [15:0] PC_RESET_VAL = 16'h0000;
   // prefix bytes
   localparam logic [7:0] PFX_Y = 8'h90; // y_swap_prefix
   localparam logic [7:0] PFX_IY = 8'h91; // y_indirect_prefix
   localparam logic [7:0] PFX_IND = 8'h92; // indirect_prefix
   // relative_invoke opcode
   localparam logic [7:0] OPC_REL_CALL = 8'had;
   // opcode high nibbles and the family each one selects
   localparam logic [3:0] NIB_BIT_JMP = 4'h0; // bit test-and-jump, short direct
   localparam logic [3:0] NIB_BIT_SET = 4'h1; // bit set/reset, short direct
   localparam logic [3:0] NIB_REL = 4'h2; // cond_relative_jump
   localparam logic [3:0] NIB_MEM_DIR = 4'h3; // short-only memory ops, direct
   localparam logic [3:0] NIB_INH_A = 4'h4; // inherent on accumulator
   localparam logic [3:0] NIB_INH_X = 4'h5; // inherent on index register
   localparam logic [3:0] NIB_MEM_IDX = 4'h6; // short-only memory ops, indexed
   localparam logic [3:0] NIB_MEM_IX0 = 4'h7; // short-only memory ops, no offset
   localparam logic [3:0] NIB_INH_8 = 4'h8; // inherent control group
   localparam logic [3:0] NIB_INH_9 = 4'h9; // inherent transfer group
   localparam logic [3:0] NIB_IMM = 4'ha;
   localparam logic [3:0] NIB_DIR_S = 4'hb;
   localparam logic [3:0] NIB_DIR_L = 4'hc;
   localparam logic [3:0] NIB_IDX_L = 4'hd;
   localparam logic [3:0] NIB_IDX_S = 4'he;
   localparam logic [3:0] NIB_IDX_0 = 4'hf;
   // addressing modes
   typedef enum logic [3:0] {
      M_INH = 4'h0,
      M_IMM = 4'h1,
      M_DIR_S = 4'h2,
      M_DIR_L = 4'h3,
      M_IDX_0 = 4'h4,
      M_IDX_S = 4'h5,
      M_IDX_L = 4'h6,
      M_IND_S = 4'h7,
      M_IND_L = 4'h8,
      M_IIX_S = 4'h9,
      M_IIX_L = 4'ha,
      M_REL_D = 4'hb,
      M_REL_I = 4'hc
   } amd_mode_t;
endpackage

// ==== amd_opcode_dec.sv ====
// opcode and prefix to addressing mode table
`timescale 1ns/10ps
module amd_opcode_dec (
   // opcode and prefix seen before it
   input wire logic [7:0] opcode_i,
   input wire logic pfx_y_i,
   input wire logic pfx_iy_i,
   input wire logic pfx_ind_i,
   // decoded mode
   output amd_pkg::amd_mode_t mode_o,
   output logic use_y_o,
   output logic illegal_o,
   output logic [1:0] opd_n_o,
   output logic [1:0] ptr_n_o
);
   import amd_pkg::*;

   logic ind;
   logic [3:0] nib;
   assign nib = opcode_i[7:4];
   assign ind = pfx_ind_i | pfx_iy_i;

   // family per nibble, then prefix conversion
   always_comb
   begin
      mode_o = M_INH;
      illegal_o = 1'b0;
      use_y_o = pfx_y_i | pfx_iy_i;
      case (nib)
         NIB_BIT_JMP, NIB_BIT_SET, NIB_MEM_DIR, NIB_DIR_S:
            mode_o = pfx_ind_i ? M_IND_S : M_DIR_S;
         NIB_DIR_L:
            mode_o = pfx_ind_i ? M_IND_L : M_DIR_L;
         NIB_REL:
            mode_o = pfx_ind_i ? M_REL_I : M_REL_D;
         NIB_MEM_IDX, NIB_IDX_S:
            mode_o = ind ? M_IIX_S : M_IDX_S;
         NIB_IDX_L:
            mode_o = ind ? M_IIX_L : M_IDX_L;
         NIB_MEM_IX0, NIB_IDX_0:
            mode_o = M_IDX_0;
         NIB_IMM:
            mode_o = (opcode_i == OPC_REL_CALL) ? (pfx_ind_i ? M_REL_I : M_REL_D)
                                                 : M_IMM;
         default:
            mode_o = M_INH;
      endcase
      // prefix legality
      if (pfx_iy_i && !(nib == NIB_MEM_IDX || nib == NIB_IDX_S || nib == NIB_IDX_L))
         illegal_o = 1'b1;
      if (pfx_ind_i && (mode_o == M_INH || mode_o == M_IMM || mode_o == M_IDX_0))
         illegal_o = 1'b1;
      if (pfx_y_i && (nib == NIB_BIT_JMP || nib == NIB_BIT_SET || nib == NIB_REL
                      || nib == NIB_MEM_DIR))
         illegal_o = 1'b1;
      if (opcode_i == PFX_Y || opcode_i == PFX_IY || opcode_i == PFX_IND)
         illegal_o = 1'b1; // a second prefix
   end

   // bytes after the opcode and pointer bytes read
   always_comb
   begin
      opd_n_o = 2'd0;
      ptr_n_o = 2'd0;
      case (mode_o)
         M_IMM, M_DIR_S, M_IDX_S, M_REL_D: opd_n_o = 2'd1;
         M_DIR_L, M_IDX_L: opd_n_o = 2'd2;
         M_IND_S, M_IIX_S, M_REL_I:
         begin
            opd_n_o = 2'd1;
            ptr_n_o = 2'd1;
         end
         M_IND_L, M_IIX_L:
         begin
            opd_n_o = 2'd1;
            ptr_n_o = 2'd2;
         end
         default: opd_n_o = 2'd0;
      endcase
      if (illegal_o)
      begin
         opd_n_o = 2'd0;
         ptr_n_o = 2'd0;
      end
   end
endmodule

// ==== amd_ea_calc.sv ====
// effective address and branch target arithmetic
`timescale 1ns/10ps
module amd_ea_calc (
   // operands
   input amd_pkg::amd_mode_t mode_i,
   input wire logic [15:0] opd_i,
   input wire logic [15:0] ptr_i,
   input wire logic [7:0] idx_i,
   input wire logic [15:0] pc_i,
   // result
   output logic [15:0] ea_o
);
   import amd_pkg::*;

   logic [15:0] idx_w;
   assign idx_w = {8'h00, idx_i};

   // unsigned index sums; short forms carry into bit 8
   always_comb
   begin
      case (mode_i)
         M_DIR_S, M_DIR_L: ea_o = opd_i;
         M_IDX_0: ea_o = idx_w;
         M_IDX_S, M_IDX_L: ea_o = opd_i + idx_w;
         M_IND_S, M_IND_L: ea_o = ptr_i;
         M_IIX_S, M_IIX_L: ea_o = ptr_i + idx_w;
         M_REL_D: ea_o = pc_i + {{8{opd_i[7]}}, opd_i[7:0]};
         M_REL_I: ea_o = pc_i + {{8{ptr_i[7]}}, ptr_i[7:0]};
         default: ea_o = 16'h0000;
      endcase
   end
endmodule

// ==== amd_mem_model.sv ====
// memory partner that answers decoder reads after a chosen wait
`timescale 1ns/10ps
module amd_mem_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // read bus
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   input wire logic [1:0] wait_i,
   output logic [7:0] rdata_o,
   output logic ack_o
);
   logic [7:0] mem [0:65535];
   logic [1:0] cnt_q;
   logic [7:0] last_q;
   // blank memory so no read ever returns an unknown
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h00;
   end
   // one ack per request, after wait_i idle cycles
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 2'h0;
         ack_o <= 1'b0;
         last_q <= 8'h00;
      end
      else if (ack_o)
      begin
         ack_o <= 1'b0;
         cnt_q <= 2'h0;
         last_q <= mem[addr_i];
      end
      else if (rd_i)
      begin
         if (cnt_q == wait_i)
            ack_o <= 1'b1;
         else
            cnt_q <= cnt_q + 2'h1;
      end
   end
   // outside the ack the data lines show the inverse of the last byte
   assign rdata_o = ack_o ? mem[addr_i] : ~last_q;
endmodule

// ==== amd_core_monitor.sv ====
// assertion checker on the decoder top ports
`timescale 1ns/10ps
module amd_core_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // memory bus and index registers
   input wire logic mem_rd_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [7:0] x_i,
   input wire logic [7:0] y_i,
   // decode result
   input wire logic busy_o,
   input wire logic done_o,
   input amd_pkg::amd_mode_t mode_o,
   input wire logic use_y_o,
   input wire logic illegal_o,
   input wire logic [7:0] operand_o,
   input wire logic [15:0] ea_o,
   input wire logic [2:0] instr_len_o,
   input wire logic [15:0] pc_o
);
   import amd_pkg::*;
   logic busy_q;
   logic [15:0] start_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // first fetch address of each instruction
   always_ff @(posedge clk_i)
   begin
      busy_q <= rst_n_i & busy_o;
      if (!rst_n_i)
         start_q <= 16'h0000;
      else if (busy_o && !busy_q)
         start_q <= mem_addr_o;
   end
   property p_inh_len;
      done_o && mode_o == M_INH && !illegal_o
         |-> instr_len_o == 3'h1 + {2'b00, use_y_o} && ea_o == 16'h0000;
   endproperty
   a_inh_len: assert property (p_inh_len) else $error("inherent length wrong");
   property p_imm_len;
      done_o && mode_o == M_IMM && !illegal_o |-> instr_len_o == 3'h2 + {2'b00, use_y_o};
   endproperty
   a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");
   property p_dir_s;
      done_o && mode_o == M_DIR_S && !illegal_o |-> ea_o == {8'h00, operand_o};
   endproperty
   a_dir_s: assert property (p_dir_s) else $error("short direct address wrong");
   property p_dir_l;
      done_o && mode_o == M_DIR_L && !illegal_o
         |-> instr_len_o == 3'h3 + {2'b00, use_y_o} && ea_o[7:0] == operand_o;
   endproperty
   a_dir_l: assert property (p_dir_l) else $error("long direct fetch wrong");
   property p_idx0;
      done_o && mode_o == M_IDX_0 && !illegal_o
         |-> ea_o == {8'h00, use_y_o ? y_i : x_i};
   endproperty
   a_idx0: assert property (p_idx0) else $error("no offset address wrong");
   property p_idx_s;
      done_o && (mode_o == M_IDX_S || mode_o == M_IIX_S) && !illegal_o |-> ea_o <= 16'h01fe;
   endproperty
   a_idx_s: assert property (p_idx_s) else $error("short indexed out of range");
   property p_rel;
      done_o && mode_o == M_REL_D |-> ea_o == pc_o + {{8{operand_o[7]}}, operand_o};
   endproperty
   a_rel: assert property (p_rel) else $error("relative target wrong");
   property p_pc_next;
      done_o |-> pc_o == start_q + {13'h0000, instr_len_o};
   endproperty
   a_pc_next: assert property (p_pc_next) else $error("next pc wrong");
   property p_rd_hold;
      mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read dropped before ack");
   // main scenarios reached
   c_iix: cover property (done_o && mode_o == M_IIX_L);
   c_rel: cover property (done_o && mode_o == M_REL_I);
   c_ill: cover property (done_o && illegal_o);
endmodule
bind amd_core amd_core_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_rd_o(mem_rd_o),
   .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .x_i(x_i), .y_i(y_i), .busy_o(busy_o),
   .done_o(done_o), .mode_o(mode_o), .use_y_o(use_y_o), .illegal_o(illegal_o),
   .operand_o(operand_o), .ea_o(ea_o), .instr_len_o(instr_len_o), .pc_o(pc_o));

// ==== addressing_mode_decoder_bench.sv ====
// self-checking bench of the addressing mode decoder
`timescale 1ns/10ps
module addressing_mode_decoder_bench;
   import amd_pkg::*;
   logic clk_i, rst_n_i, en_i, go_i, pc_load_i, mem_rd_o, mem_ack_i;
   logic busy_o, done_o, use_y_o, illegal_o;
   logic [15:0] pc_value_i, mem_addr_o, ea_o, pc_o;
   logic [7:0] x_i, y_i, mem_rdata_i, opcode_o, operand_o;
   logic [2:0] instr_len_o;
   logic [1:0] mem_wait;
   amd_mode_t mode_o;
   int failures = 0;
   int compares = 0;
   amd_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .go_i(go_i),
      .pc_load_i(pc_load_i), .pc_value_i(pc_value_i), .x_i(x_i), .y_i(y_i),
      .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
      .mem_ack_i(mem_ack_i), .busy_o(busy_o), .done_o(done_o), .opcode_o(opcode_o),
      .mode_o(mode_o), .use_y_o(use_y_o), .illegal_o(illegal_o), .operand_o(operand_o),
      .ea_o(ea_o), .instr_len_o(instr_len_o), .pc_o(pc_o));
   amd_mem_model mdl (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_i(mem_rd_o),
      .addr_i(mem_addr_o), .wait_i(mem_wait), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
   // 50 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic test_done();
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // place bytes at 0100, decode them and judge every result but operand_o; mode, ea and use_y_o only when legal
   task automatic dec(input logic [7:0] b0, b1, b2, xv, yv, input amd_mode_t m,
      input logic [2:0] len, input logic [15:0] ea, input logic yy, ill);
      int n;
      logic [7:0] op;
      // the opcode reported is the byte after any prefix
      op = (b0 == PFX_Y || b0 == PFX_IY || b0 == PFX_IND) ? b1 : b0;
      mdl.mem[16'h0100] = b0;
      mdl.mem[16'h0101] = b1;
      mdl.mem[16'h0102] = b2;
      x_i = xv;
      y_i = yv;
      pc_load_i = 1'b1;
      @(negedge clk_i);
      pc_load_i = 1'b0;
      go_i = 1'b1;
      @(negedge clk_i);
      go_i = 1'b0;
      chk({15'h0, busy_o}, 16'h0001);
      n = 0;
      while (done_o !== 1'b1 && n < 60)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n == 60)
      begin
         failures++;
         test_done();
      end
      chk({13'h0, instr_len_o}, {13'h0, len});
      chk({15'h0, illegal_o}, {15'h0, ill});
      chk(pc_o, 16'h0100 + {13'h0, len});
      chk({8'h0, opcode_o}, {8'h0, op});
      chk({15'h0, busy_o}, 16'h0000);
      if (!ill)
      begin
         chk({12'h0, mode_o}, {12'h0, m});
         chk(ea_o, ea);
         chk({15'h0, use_y_o}, {15'h0, yy});
      end
      @(negedge clk_i);
      chk({15'h0, done_o}, 16'h0000);
   endtask
   task automatic t_inherent();
      logic [7:0] ops [4] = '{8'h4c, 8'h5c, 8'h80, 8'h9d};
      foreach (ops[i])
         dec(ops[i], 8'h00, 8'h00, 8'h11, 8'h22, M_INH, 3'h1, 16'h0000, 1'b0, 1'b0);
      dec(PFX_Y, 8'h5c, 8'h00, 8'h11, 8'h22, M_INH, 3'h2, 16'h0000, 1'b1, 1'b0);
   endtask
   task automatic t_immediate();
      dec(8'ha6, 8'h55, 8'h00, 8'h00, 8'h00, M_IMM, 3'h2, 16'h0000, 1'b0, 1'b0);
      chk({8'h00, operand_o}, 16'h0055);
      dec(PFX_Y, 8'ha6, 8'h55, 8'h00, 8'h00, M_IMM, 3'h3, 16'h0000, 1'b1, 1'b0);
      dec(PFX_IY, 8'ha6, 8'h55, 8'h00, 8'h00, M_IMM, 3'h2, 16'h0000, 1'b0, 1'b1);
      dec(PFX_IND, 8'ha6, 8'h55, 8'h00, 8'h00, M_IMM, 3'h2, 16'h0000, 1'b0, 1'b1);
   endtask
   task automatic t_direct();
      dec(8'hb6, 8'h80, 8'h00, 8'h00, 8'h00, M_DIR_S, 3'h2, 16'h0080, 1'b0, 1'b0);
      mem_wait = 2'h3;
      dec(8'hc6, 8'h12, 8'h34, 8'h00, 8'h00, M_DIR_L, 3'h3, 16'h1234,
         1'b0, 1'b0);
      mem_wait = 2'h0;
      dec(8'h36, 8'hff, 8'h00, 8'h00, 8'h00, M_DIR_S, 3'h2, 16'h00ff, 1'b0, 1'b0);
      dec(8'h14, 8'h44, 8'h00, 8'h00, 8'h00, M_DIR_S, 3'h2, 16'h0044, 1'b0, 1'b0);
      dec(PFX_Y, 8'h14, 8'h44, 8'h00, 8'h00, M_DIR_S, 3'h2, 16'h0000, 1'b0, 1'b1);
   endtask
   task automatic t_indexed();
      dec(8'hf6, 8'h00, 8'h00, 8'hff, 8'h00, M_IDX_0, 3'h1, 16'h00ff, 1'b0, 1'b0);
      dec(PFX_Y, 8'hf6, 8'h00, 8'h01, 8'h7e, M_IDX_0, 3'h2, 16'h007e, 1'b1, 1'b0);
      dec(8'he6, 8'hff, 8'h00, 8'hff, 8'h00, M_IDX_S, 3'h2, 16'h01fe, 1'b0, 1'b0);
      dec(8'hd6, 8'hff, 8'hf0, 8'h20, 8'h00, M_IDX_L, 3'h3, 16'h0010,
         1'b0, 1'b0);
      dec(8'h66, 8'h10, 8'h00, 8'h05, 8'h00, M_IDX_S, 3'h2, 16'h0015, 1'b0, 1'b0);
      dec(PFX_IND, 8'h76, 8'h00, 8'h05, 8'h00, M_INH, 3'h2, 16'h0000, 1'b0, 1'b1);
      dec(PFX_Y, PFX_IND, 8'h00, 8'h00, 8'h00, M_INH, 3'h2, 16'h0000, 1'b0, 1'b1);
   endtask
   task automatic t_indirect();
      mdl.mem[16'h0030] = 8'h77;
      mdl.mem[16'h0040] = 8'hab;
      mdl.mem[16'h0041] = 8'hcd;
      mdl.mem[16'h0050] = 8'hf0;
      mdl.mem[16'h0060] = 8'h12;
      mdl.mem[16'h0061] = 8'hf0;
      dec(PFX_IND, 8'hb6, 8'h30, 8'h00, 8'h00, M_IND_S, 3'h3, 16'h0077,
         1'b0, 1'b0);
      mem_wait = 2'h2;
      dec(PFX_IND, 8'hc6, 8'h40, 8'h00, 8'h00, M_IND_L, 3'h3, 16'habcd,
         1'b0, 1'b0);
      mem_wait = 2'h0;
      dec(PFX_IND, 8'he6, 8'h50, 8'h20, 8'h00, M_IIX_S, 3'h3, 16'h0110,
         1'b0, 1'b0);
      dec(PFX_IY, 8'hd6, 8'h60, 8'h00, 8'h20, M_IIX_L, 3'h3, 16'h1310,
         1'b1, 1'b0);
      dec(PFX_IND, 8'h3a, 8'h30, 8'h00, 8'h00, M_IND_S, 3'h3, 16'h0077, 1'b0, 1'b0);
      dec(PFX_IND, 8'h00, 8'h30, 8'h00, 8'h00, M_IND_S, 3'h3, 16'h0077, 1'b0, 1'b0);
   endtask
   // a low enable must keep an idle decoder from starting a fetch
   task automatic t_enable();
      en_i = 1'b0;
      go_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk({15'h0, busy_o}, 16'h0000);
      chk({15'h0, mem_rd_o}, 16'h0000);
      go_i = 1'b0;
      en_i = 1'b1;
      @(negedge clk_i);
   endtask
   task automatic t_relative();
      mdl.mem[16'h0034] = 8'h05;
      dec(8'h27, 8'hfe, 8'h00, 8'h00, 8'h00, M_REL_D, 3'h2, 16'h0100,
         1'b0, 1'b0);
      dec(8'h2e, 8'h7f, 8'h00, 8'h00, 8'h00, M_REL_D, 3'h2, 16'h0181, 1'b0, 1'b0);
      dec(OPC_REL_CALL, 8'h80, 8'h00, 8'h00, 8'h00, M_REL_D, 3'h2, 16'h0082,
         1'b0, 1'b0);
      dec(PFX_IND, 8'h27, 8'h34, 8'h00, 8'h00, M_REL_I, 3'h3, 16'h0108, 1'b0, 1'b0);
   endtask
   // reset, then every scenario in turn
   initial
   begin
      rst_n_i = 1'b0;
      en_i = 1'b1;
      go_i = 1'b0;
      pc_load_i = 1'b0;
      pc_value_i = 16'h0100;
      x_i = 8'h00;
      y_i = 8'h00;
      mem_wait = 2'h0;
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_inherent();
      t_immediate();
      t_direct();
      t_indexed();
      t_indirect();
      t_enable();
      t_relative();
      test_done();
   end
endmodule
